// >>> lfafe_regs.vh
// constants for the lf front end control block: register offsets, fields, timing
// assumes a 32-bit apb slave; each register is one aligned word
`ifndef LFAFE_REGS_VH
`define LFAFE_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define LFAFE_CFG0_OFS 12'h000
`define LFAFE_CFG5_OFS 12'h014
`define LFAFE_CMD_OFS 12'h020
`define LFAFE_STAT_OFS 12'h01C

// ----------------------------------------
// field positions
// ----------------------------------------
`define LFAFE_CFG0_CHEN_LO 1
`define LFAFE_CFG5_MIN_MOD_DEPTH_SELECT_LO 5
`define LFAFE_CFG5_GATE_BIT 7
`define LFAFE_STAT_ACT_BIT 5

// ----------------------------------------
// reset values
// ----------------------------------------
`define LFAFE_CFG0_RST 9'h000
`define LFAFE_CFG5_RST 9'h000

// ----------------------------------------
// commands written to the command register
// ----------------------------------------
`define LFAFE_CMD_SRST 3'h1
`define LFAFE_CMD_SLEEP 3'h2
`define LFAFE_CMD_PRSV_ON 3'h3
`define LFAFE_CMD_PRSV_OFF 3'h4

// ----------------------------------------
// modulation depth thresholds in percent
// ----------------------------------------
`define LFAFE_DEPTH_00 7'h21
`define LFAFE_DEPTH_01 7'h3C
`define LFAFE_DEPTH_10 7'h0E
`define LFAFE_DEPTH_11 7'h08

// ----------------------------------------
// timing
// ----------------------------------------
`define LFAFE_CLK_HZ 25000000
`define LFAFE_OSC_HZ 32000
`define LFAFE_SRST_NS 31250
`define LFAFE_SRST_CYC ((`LFAFE_SRST_NS * (`LFAFE_CLK_HZ / 1000000) + 999) / 1000)
`define LFAFE_AGC_US 3500
`define LFAFE_AGC_CYC (`LFAFE_AGC_US * (`LFAFE_CLK_HZ / 1000000))

`endif

// >>> lfafe_ctrl.v
// control logic of a three channel lf receiver front end: modes, soft reset,
// gain loop phase sequencing, gain preserve, output gating, depth select.
// assumes an apb master on pclk; analog indications arrive asynchronously
// and pass two flip-flops; the link clock is sampled like any other pin.
// What this block does
// - status flag shows gain loop regulating
// - gate option holds outputs until loop active
// - three channel enable bits in config zero
// - disabled channel powered down, limiter kept
// - fast loop during init, slow afterwards
// - gain frozen while envelope low
// - preserve captures gain at each init interval end while envelope high
// - soft reset from timer, abort, command; the por request is dropped in standby
// - abort when no signal at init end
// - soft reset reinits circuits, enters standby
// - soft reset keeps configuration registers
// - soft reset lasts one oscillator cycle
// - modulation transistors on during soft reset
// - soft reset only acts in active mode
// - depth field decodes to four thresholds
// - data only above selected modulation depth
// - sleep powers down everything but registers
// - any other command or por wakes
// - standby when no input present
// - active when input appears on any enabled pin
`include "lfafe_regs.vh"

module lfafe_ctrl #(
	parameter AGC_CYC = `LFAFE_AGC_CYC,
	parameter NCH = 3
) (
	input wire pclk,
	input wire presetn,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [NCH-1:0] sig_present,
	input wire envelope_high,
	input wire loop_regulating,
	input wire [6:0] mod_depth_pct,
	input wire demod_in,
	input wire carrier_clk,
	input wire inactivity_expired,
	output reg data_out,
	output reg carrier_out,
	output reg [NCH-1:0] ch_power_en,
	output reg [NCH-1:0] limiter_power_en,
	output reg [NCH-1:0] mod_fet_on,
	output reg gain_fast,
	output reg gain_update_en,
	output reg gain_capture,
	output reg gain_use_preserved,
	output reg circuit_init,
	output reg [1:0] power_mode,
	output reg [6:0] min_depth_pct
);

	// ----------------------------------------
	// modes and constants
	// ----------------------------------------
	localparam [1:0] M_SLEEP = 2'b00;
	localparam [1:0] M_STANDBY = 2'b01;
	localparam [1:0] M_ACTIVE = 2'b10;
	localparam [31:0] SRST_CYC = `LFAFE_SRST_CYC;
	localparam [31:0] AGC_LEN = AGC_CYC;

	// ----------------------------------------
	// register map and sequencing
	// ----------------------------------------
	// cfg0 at 0x000: bits 3:1 enable the three channels, other bits only stored
	// cfg5 at 0x014: bits 6:5 pick the depth threshold, bit 7 gates the outputs
	// status at 0x01c, read only: bit 5 loop regulating, bits 1:0 power mode
	// command at 0x020, write only: 1 soft reset, 2 sleep, 3 preserve on,
	// 4 preserve off; any other code is accepted and only wakes the block
	// unmapped offsets answer with pslverr in the access phase and read zero
	// every access is one setup and one access cycle; pready never drops
	// read data is loaded in the setup cycle and stands until the next read
	//
	// standby -> active once an enabled channel shows a carrier; the init
	// interval then runs with the fast loop for AGC_CYC cycles
	// a carrier gone at the end of the interval aborts into a soft reset
	// soft reset holds circuit_init and the discharge switches for SRST_CYC
	// cycles, then drops to standby; configuration survives it
	// a soft reset request outside active is dropped, which is why the one
	// raised by por is lost when the block leaves reset in standby
	// sleep is left only by por or by a command other than sleep
	//
	// limitation: channel inputs are treated as levels; a carrier that drops
	// for a few cycles inside the init interval is not caught here, only its
	// absence at the end of the interval counts
	// the analog depth word is synchronised bit by bit, safe only because it
	// moves far slower than pclk; a changing word may be seen torn for a cycle

	function [6:0] depth_decode;
		input [1:0] sel;
		begin
			case (sel)
				2'b00: depth_decode = `LFAFE_DEPTH_00;
				2'b01: depth_decode = `LFAFE_DEPTH_01;
				2'b10: depth_decode = `LFAFE_DEPTH_10;
				default: depth_decode = `LFAFE_DEPTH_11;
			endcase
		end
	endfunction

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	reg [NCH+11:0] sync1_reg;
	reg [NCH+11:0] sync2_reg;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= {(NCH+12){1'b0}};
			sync2_reg <= {(NCH+12){1'b0}};
		end else if (clk_en) begin
			sync1_reg <= {sig_present, envelope_high, loop_regulating, mod_depth_pct,
				demod_in, carrier_clk, inactivity_expired};
			sync2_reg <= sync1_reg;
		end
	end
	wire [NCH-1:0] s_sig = sync2_reg[NCH+11:12];
	wire s_env = sync2_reg[11];
	wire s_reg_loop = sync2_reg[10];
	wire [6:0] s_depth = sync2_reg[9:3];
	wire s_demod = sync2_reg[2];
	wire s_carrier = sync2_reg[1];
	wire s_inact = sync2_reg[0];
	reg inact_d_reg;

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	reg [8:0] cfg0_reg;
	reg [8:0] cfg5_reg;
	wire apb_wr = psel && penable && pwrite;
	wire apb_rd_set = psel && !penable && !pwrite;
	wire addr_ok = (paddr == `LFAFE_CFG0_OFS) || (paddr == `LFAFE_CFG5_OFS) ||
		(paddr == `LFAFE_CMD_OFS) || (paddr == `LFAFE_STAT_OFS);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	wire cmd_wr = apb_wr && (paddr == `LFAFE_CMD_OFS) && clk_en;
	wire [2:0] cmd = pwdata[2:0];

	reg gain_act_reg;
	wire [NCH-1:0] ch_en = cfg0_reg[`LFAFE_CFG0_CHEN_LO+NCH-1:`LFAFE_CFG0_CHEN_LO];
	wire gate_opt = cfg5_reg[`LFAFE_CFG5_GATE_BIT];
	wire [1:0] depth_sel = cfg5_reg[`LFAFE_CFG5_MIN_MOD_DEPTH_SELECT_LO+1:`LFAFE_CFG5_MIN_MOD_DEPTH_SELECT_LO];

	// soft reset leaves configuration alone: only por clears it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg0_reg <= `LFAFE_CFG0_RST;
			cfg5_reg <= `LFAFE_CFG5_RST;
		end else if (clk_en && apb_wr) begin
			if (paddr == `LFAFE_CFG0_OFS)
				cfg0_reg <= pwdata[8:0];
			if (paddr == `LFAFE_CFG5_OFS)
				cfg5_reg <= pwdata[8:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (clk_en && apb_rd_set) begin
			case (paddr)
				`LFAFE_CFG0_OFS: prdata <= {23'h00_0000, cfg0_reg};
				`LFAFE_CFG5_OFS: prdata <= {23'h00_0000, cfg5_reg};
				`LFAFE_STAT_OFS: prdata <= {26'h000_0000, gain_act_reg, 3'h0, power_mode};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// power mode, soft reset and gain init sequencing
	// ----------------------------------------
	reg [1:0] mode_reg;
	reg [31:0] srst_cnt_reg;
	reg [31:0] agc_cnt_reg;
	reg agc_run_reg;
	reg srst_req_reg;
	reg prsv_reg;
	wire any_sig = |(s_sig & ch_en);
	wire agc_end = agc_run_reg && (agc_cnt_reg == AGC_LEN - 1);
	wire abort = agc_end && !any_sig;
	wire inact_evt = s_inact && !inact_d_reg;
	wire srst_src = srst_req_reg || abort || inact_evt ||
		(cmd_wr && cmd == `LFAFE_CMD_SRST);
	wire srst_busy = (srst_cnt_reg != 32'd0);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= M_STANDBY;
			srst_cnt_reg <= 32'd0;
			agc_cnt_reg <= 32'd0;
			agc_run_reg <= 1'b0;
			srst_req_reg <= 1'b1; // por raises a soft reset request, dropped in standby
			prsv_reg <= 1'b0;
			inact_d_reg <= 1'b0;
			gain_act_reg <= 1'b0;
		end else if (clk_en) begin
			inact_d_reg <= s_inact;
			gain_act_reg <= s_reg_loop && (mode_reg == M_ACTIVE);
			if (cmd_wr && cmd == `LFAFE_CMD_PRSV_ON)
				prsv_reg <= 1'b1;
			else if (cmd_wr && cmd == `LFAFE_CMD_PRSV_OFF)
				prsv_reg <= 1'b0;
			case (mode_reg)
				M_SLEEP: begin
					srst_req_reg <= 1'b0;
					if (cmd_wr && cmd != `LFAFE_CMD_SLEEP)
						mode_reg <= M_STANDBY;
				end
				M_STANDBY: begin
					srst_req_reg <= 1'b0;
					if (cmd_wr && cmd == `LFAFE_CMD_SLEEP) begin
						mode_reg <= M_SLEEP;
					end else if (any_sig) begin
						mode_reg <= M_ACTIVE;
						agc_run_reg <= 1'b1;
						agc_cnt_reg <= 32'd0;
					end
				end
				M_ACTIVE: begin
					if (cmd_wr && cmd == `LFAFE_CMD_SLEEP) begin
						mode_reg <= M_SLEEP;
						agc_run_reg <= 1'b0;
						srst_cnt_reg <= 32'd0;
					end else if (srst_busy) begin
						if (srst_cnt_reg == 32'd1) begin
							mode_reg <= M_STANDBY;
						end
						srst_cnt_reg <= srst_cnt_reg - 32'd1;
					end else if (srst_src) begin
						srst_req_reg <= 1'b0;
						srst_cnt_reg <= SRST_CYC;
						agc_run_reg <= 1'b0;
						agc_cnt_reg <= 32'd0;
						if (cmd_wr && cmd == `LFAFE_CMD_SRST)
							prsv_reg <= 1'b0;
					end else if (agc_run_reg) begin
						if (agc_end)
							agc_run_reg <= 1'b0;
						else
							agc_cnt_reg <= agc_cnt_reg + 32'd1;
					end else if (!any_sig) begin
						mode_reg <= M_STANDBY;
					end
				end
				default: mode_reg <= M_STANDBY;
			endcase
		end
	end

	// ----------------------------------------
	// registered outputs: gated data path
	// ----------------------------------------
	wire awake = (mode_reg != M_SLEEP);
	wire active = (mode_reg == M_ACTIVE) && !srst_busy;
	wire gate_ok = !gate_opt || gain_act_reg;
	wire depth_ok = (s_depth > depth_decode(depth_sel));
	// nothing passes during the init interval: the fast loop gain is not yet
	// fit for slicing, and the carrier follows the same gate as the data
	wire pass_ok = active && !agc_run_reg && gate_ok && depth_ok;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_out <= 1'b0;
			carrier_out <= 1'b0;
		end else if (clk_en) begin
			data_out <= pass_ok && s_demod;
			carrier_out <= pass_ok && s_carrier;
		end
	end

	// ----------------------------------------
	// registered outputs: channel power
	// ----------------------------------------
	// limiters stay on whenever awake, enabled or not, to clamp the antenna
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch_power_en <= {NCH{1'b0}};
			limiter_power_en <= {NCH{1'b0}};
			mod_fet_on <= {NCH{1'b0}};
		end else if (clk_en) begin
			ch_power_en <= awake ? ch_en : {NCH{1'b0}};
			limiter_power_en <= awake ? {NCH{1'b1}} : {NCH{1'b0}};
			mod_fet_on <= srst_busy ? ch_en : {NCH{1'b0}};
		end
	end

	// ----------------------------------------
	// registered outputs: gain loop control
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_fast <= 1'b0;
			gain_update_en <= 1'b0;
			gain_capture <= 1'b0;
			gain_use_preserved <= 1'b0;
		end else if (clk_en) begin
			gain_fast <= active && agc_run_reg;
			gain_update_en <= active && s_env;
			gain_capture <= active && agc_end && prsv_reg && s_env;
			gain_use_preserved <= prsv_reg;
		end
	end

	// ----------------------------------------
	// registered outputs: status
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			circuit_init <= 1'b0;
			power_mode <= M_STANDBY;
			min_depth_pct <= `LFAFE_DEPTH_00;
		end else if (clk_en) begin
			circuit_init <= srst_busy;
			power_mode <= mode_reg;
			min_depth_pct <= depth_decode(depth_sel);
		end
	end

endmodule // lfafe_ctrl

// >>> lfafe_monitor.sv
// checker for lfafe_ctrl, bound to its ports
// assumes one pclk domain, presetn async low, clk_en held high
module lfafe_monitor (
	input wire pclk,
	input wire presetn,
	input wire [2:0] limiter_power_en,
	input wire [2:0] mod_fet_on,
	input wire gain_fast,
	input wire circuit_init,
	input wire data_out,
	input wire [1:0] power_mode,
	input wire [6:0] min_depth_pct
);
	localparam int SRST_CYC = 782;
	logic [11:0] init_cnt;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			init_cnt <= 12'h000;
		else if (circuit_init)
			init_cnt <= init_cnt + 12'h001;
		else
			init_cnt <= 12'h000;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_len; $fell(circuit_init) |-> init_cnt == SRST_CYC; endproperty
	a_len: assert property (p_len) else $error("soft reset length wrong");
	property p_fet; mod_fet_on != 3'b000 |-> circuit_init; endproperty
	a_fet: assert property (p_fet) else $error("fet on outside init");
	property p_stby; $fell(circuit_init) |-> ##[0:2] power_mode == 2'b01; endproperty
	a_stby: assert property (p_stby) else $error("no standby after init");
	property p_fast; gain_fast |-> power_mode == 2'b10; endproperty
	a_fast: assert property (p_fast) else $error("fast loop outside active");
	property p_data; data_out |-> power_mode == 2'b10; endproperty
	a_data: assert property (p_data) else $error("data outside active");
	property p_slp; (power_mode == 2'b00) [*3] |-> limiter_power_en == 3'b000; endproperty
	a_slp: assert property (p_slp) else $error("limiter on in sleep");
	property p_lim; (power_mode != 2'b00) [*3] |-> limiter_power_en == 3'b111; endproperty
	a_lim: assert property (p_lim) else $error("limiter off when awake");
	property p_dep; min_depth_pct inside {7'h21, 7'h3C, 7'h0E, 7'h08}; endproperty
	a_dep: assert property (p_dep) else $error("bad depth threshold");
	property p_act; $rose(circuit_init) |-> $past(power_mode) == 2'b10; endproperty
	a_act: assert property (p_act) else $error("soft reset outside active");
endmodule // lfafe_monitor

bind lfafe_ctrl lfafe_monitor u_lfafe_monitor (.pclk(pclk), .presetn(presetn),
	.limiter_power_en(limiter_power_en), .mod_fet_on(mod_fet_on), .gain_fast(gain_fast),
	.circuit_init(circuit_init), .data_out(data_out), .power_mode(power_mode),
	.min_depth_pct(min_depth_pct));

// >>> lfafe_field.sv
// model of the analog channels feeding the control block
// assumes the bench raises on for a frame; the carrier stands still outside frames
module lfafe_field (
	input wire on,
	input wire lvl,
	input wire [2:0] ch,
	output logic [2:0] sig_present,
	output logic envelope_high,
	output logic loop_regulating,
	output logic demod_in,
	output logic carrier_clk
);
	timeunit 1ns;
	timeprecision 1ns;
	initial carrier_clk = 1'b0;
	initial demod_in = 1'b0;
	always #160 carrier_clk = on ? ~carrier_clk : 1'b0;
	// slow data pattern, toggling every 640 ns, always on a falling edge of pclk
	always #640 demod_in = on ? ~demod_in : 1'b0;
	assign sig_present = on ? ch : 3'b000;
	assign envelope_high = on & demod_in;
	assign loop_regulating = on & lvl;
endmodule // lfafe_field

// >>> lfafe_ctrl_tb.sv
// self-checking bench for lfafe_ctrl over apb with an analog channel model
// assumes a shortened gain init interval of 20 cycles
`include "lfafe_regs.vh"
module lfafe_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, psel, penable, pwrite, on, lvl, clr, err;
	logic [2:0] seen;
	logic clk_en = 1'b1, inactivity_expired = 1'b0;
	logic [6:0] mod_depth_pct = 7'h32;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	logic [2:0] ch;
	logic [6:0] dep [4] = '{7'h21, 7'h3C, 7'h0E, 7'h08};
	wire [31:0] prdata;
	wire pready, pslverr, data_out, carrier_out, gain_fast, gain_update_en, gain_capture;
	wire gain_use_preserved, circuit_init, envelope_high, loop_regulating, demod_in, carrier_clk;
	wire [2:0] ch_power_en, limiter_power_en, mod_fet_on, sig_present;
	wire [1:0] power_mode;
	wire [6:0] min_depth_pct;
	int errors, n_checks, i, k;
	lfafe_ctrl #(.AGC_CYC(20)) u_lfafe_ctrl (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sig_present(sig_present),
		.envelope_high(envelope_high), .loop_regulating(loop_regulating),
		.mod_depth_pct(mod_depth_pct), .demod_in(demod_in), .carrier_clk(carrier_clk),
		.inactivity_expired(inactivity_expired), .data_out(data_out),
		.carrier_out(carrier_out), .ch_power_en(ch_power_en),
		.limiter_power_en(limiter_power_en), .mod_fet_on(mod_fet_on), .gain_fast(gain_fast),
		.gain_update_en(gain_update_en), .gain_capture(gain_capture),
		.gain_use_preserved(gain_use_preserved), .circuit_init(circuit_init),
		.power_mode(power_mode), .min_depth_pct(min_depth_pct));
	lfafe_field u_lfafe_field (.on(on), .lvl(lvl), .ch(ch), .sig_present(sig_present),
		.envelope_high(envelope_high), .loop_regulating(loop_regulating),
		.demod_in(demod_in), .carrier_clk(carrier_clk));
	// ----
	// tasks
	// ----
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wm(input logic [1:0] m);
		for (i = 0; i < 400 && power_mode !== m; i++) @(posedge pclk);
		chk(power_mode, m);
	endtask
	task wi(input logic v);
		for (i = 0; i < 1000 && circuit_init !== v; i++) @(posedge pclk);
		chk(circuit_init, v);
	endtask
	task clear_seen;
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
	endtask
	task give_verdict;
		if (errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// seen holds {gain update, carrier out, data out} since the last clear
	always @(posedge pclk) begin
		if (!presetn || clr)
			seen <= 3'b000;
		else
			seen <= seen | {gain_update_en === 1'b1, carrier_out === 1'b1, data_out === 1'b1};
	end
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// long enough for three soft resets and every frame
	initial begin
		#(40 * 30000);
		errors++;
		give_verdict;
	end
	initial begin
		{presetn, psel, penable, pwrite, on, lvl, clr} = 7'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		ch = 3'b001;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		chk(power_mode, 2'b01);
		chk(min_depth_pct, 7'h21);
		for (k = 0; k < 4; k++) begin
			apb(1'b1, `LFAFE_CFG5_OFS, k << 5);
			repeat (2) @(posedge pclk);
			chk(min_depth_pct, dep[k]);
		end
		apb(1'b1, `LFAFE_CFG0_OFS, 32'h0000_0002);
		apb(1'b0, `LFAFE_CFG0_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_0002);
		chk(ch_power_en, 3'b001);
		chk(limiter_power_en, 3'b111);
		// a write while the clock enable is low must not land
		clk_en <= 1'b0;
		apb(1'b1, `LFAFE_CFG0_OFS, 32'h0000_000E);
		clk_en <= 1'b1;
		apb(1'b0, `LFAFE_CFG0_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_0002);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(err, 1'b1);
		chk(rd, 32'h0000_0000);
		apb(1'b1, `LFAFE_CFG5_OFS, 32'h0000_0080);
		clear_seen;
		on <= 1'b1;
		wm(2'b10);
		chk(gain_fast, 1'b1);
		repeat (200) @(posedge pclk);
		chk(gain_fast, 1'b0);
		chk(seen[1:0], 2'b00);
		chk(seen[2], 1'b1);
		apb(1'b0, `LFAFE_STAT_OFS, 32'h0000_0000);
		chk(rd[5], 1'b0);
		lvl <= 1'b1;
		repeat (200) @(posedge pclk);
		chk(seen[1:0], 2'b11);
		apb(1'b0, `LFAFE_STAT_OFS, 32'h0000_0000);
		chk(rd[5], 1'b1);
		mod_depth_pct <= 7'h10;
		repeat (4) @(posedge pclk);
		clear_seen;
		repeat (100) @(posedge pclk);
		chk(seen[1:0], 2'b00);
		mod_depth_pct <= 7'h32;
		repeat (4) @(posedge pclk);
		apb(1'b1, `LFAFE_CMD_OFS, `LFAFE_CMD_SRST);
		wi(1'b1);
		chk(mod_fet_on, 3'b001);
		on <= 1'b0;
		wi(1'b0);
		wm(2'b01);
		apb(1'b0, `LFAFE_CFG0_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_0002);
		apb(1'b1, `LFAFE_CMD_OFS, `LFAFE_CMD_SRST);
		repeat (5) @(posedge pclk);
		chk(circuit_init, 1'b0);
		on <= 1'b1;
		wm(2'b10);
		on <= 1'b0;
		wi(1'b1);
		wi(1'b0);
		on <= 1'b1;
		wm(2'b10);
		repeat (40) @(posedge pclk);
		inactivity_expired <= 1'b1;
		wi(1'b1);
		inactivity_expired <= 1'b0;
		on <= 1'b0;
		wi(1'b0);
		wm(2'b01);
		apb(1'b1, `LFAFE_CMD_OFS, `LFAFE_CMD_PRSV_ON);
		for (k = 0; k < 2; k++) begin
			on <= 1'b1;
			wm(2'b10);
			repeat (60) @(posedge pclk);
			chk(gain_use_preserved, 1'b1);
			on <= 1'b0;
			wm(2'b01);
		end
		apb(1'b1, `LFAFE_CMD_OFS, `LFAFE_CMD_PRSV_OFF);
		repeat (3) @(posedge pclk);
		chk(gain_use_preserved, 1'b0);
		for (k = 0; k < 2; k++) apb(1'b1, `LFAFE_CMD_OFS, `LFAFE_CMD_SLEEP);
		repeat (3) @(posedge pclk);
		chk({power_mode, limiter_power_en}, 5'b00000);
		apb(1'b1, `LFAFE_CMD_OFS, `LFAFE_CMD_PRSV_OFF);
		wm(2'b01);
		apb(1'b1, `LFAFE_CMD_OFS, `LFAFE_CMD_SLEEP);
		wm(2'b00);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(power_mode, 2'b01);
		presetn <= 1'b1;
		apb(1'b0, `LFAFE_CFG0_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		give_verdict;
	end
endmodule // lfafe_ctrl_tb
